// ==== rtl/bcds_pkg.sv ====
/*
  Shared constants, types and helper functions of the bus clock domain sync block.
  Assumes one core clock (sys_clk) and two bus clock domains whose clocks arrive as plain inputs.
*/
// What this block does
// - Functional clocking is split into three domains: core, fetch/read/write bus and peripheral/DMA bus.
// - Fetch, data read and data write ports belong to the fetch/read/write bus clock, DMA and peripheral to the other.
// - Any clock may stop for any time and no state is lost while it is stopped.
// - Each bus domain is set up on its own as synchronous or asynchronous to the core.
// - In synchronous mode the register on the outgoing request path is bypassed, shortening latency.
// - In asynchronous mode the block works with the core clock faster than the bus clock, which it samples on sys_clk.
// - Each bus domain has one bus clock input and two static synchronous-select inputs of its own.
// - Both select inputs high bypass the bus input synchronisers of that domain; any other setting uses the synchronisers.
// - A synchronous bus port runs n:1 to the core, qualified by an enable sampled on core edges.
// - One enable serves fetch, read and write; the DMA and peripheral ports each have their own.
// - At 1:1 with zero-wait slaves an uncached read costs six cycles over a hit on data, five on fetch.
package bcds_pkg;

  // ****************************************
  // Sizes and indices
  // ****************************************
  localparam int NUM_PORTS = 5;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES = 2;

  localparam int PORT_FETCH = 0;
  localparam int PORT_READ = 1;
  localparam int PORT_WRITE = 2;
  localparam int PORT_DMA = 3;
  localparam int PORT_PERIPH = 4;

  // Enable lane inside a domain tick pair
  localparam int LANE_SHARED = 0;
  localparam int LANE_DMA = 0;
  localparam int LANE_PERIPH = 1;

  // Domain codes
  localparam logic [1:0] DOM_CORE = 2'h0;
  localparam logic [1:0] DOM_FETCH_RW = 2'h1;
  localparam logic [1:0] DOM_PERIPH_DMA = 2'h2;

  // ****************************************
  // Bus encodings and reset values
  // ****************************************
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic RESP_OKAY = 1'h0;
  localparam logic SYNC_SEL_RESET = 1'h0;

  // Uncached read penalty over a hit at 1:1 synchronous clocking
  localparam int READ_PENALTY_DATA = 6;
  localparam int READ_PENALTY_FETCH = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3,
    ST_RESP = 2'h2
  } bcds_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
  } bcds_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } bcds_rsp_t;

  typedef struct packed {
    logic [1:0] trans;
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
  } bcds_bus_out_t;

  typedef struct packed {
    logic ready;
    logic resp;
    logic [DATA_W-1:0] rdata;
  } bcds_bus_in_t;

  localparam bcds_bus_out_t BUS_OUT_RESET = '{trans: TRANS_IDLE, addr: '0, write: 1'b0, wdata: '0};

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [1:0] bcds_port_domain(input int port);
    return (port <= PORT_WRITE) ? DOM_FETCH_RW : DOM_PERIPH_DMA;
  endfunction

  function automatic int bcds_port_lane(input int port);
    return (port == PORT_PERIPH) ? LANE_PERIPH : LANE_SHARED;
  endfunction

endpackage

// ==== rtl/bcds_sync.sv ====
/*
  Two-flop level synchroniser of configurable width.
  Assumes the input is a level from outside the sys_clk domain or a quasi-static word.
*/
`timescale 1ns/1ps
module bcds_sync
  import bcds_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1;

  // ****************************************
  // Synchroniser chain
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ==== rtl/bcds_tick.sv ====
/*
  Per-bus-domain advance generator: samples the bus clock and the two select inputs,
  and yields one advance pulse per enable lane.
  Assumes select inputs are static and the enables come from logic on sys_clk.
*/
`timescale 1ns/1ps
module bcds_tick
  import bcds_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Domain pins
  input wire logic busClock,
  input wire logic syncSelectA,
  input wire logic syncSelectB,
  input wire logic [1:0] busClockEnable,
  // Derived controls
  output logic [1:0] tick,
  output logic syncMode,
  output logic selectMismatch
);

  logic [2:0] pinSync;
  logic clockLast;

  bcds_sync #(.W(3)) u_pins (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({busClock, syncSelectA, syncSelectB}),
    .syncOut(pinSync)
  );

  // ****************************************
  // Bus clock edge detect
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clockLast <= 1'b0;
    end else begin
      clockLast <= pinSync[2];
    end
  end

  // In asynchronous mode a stopped bus clock yields no edges, so the bus side state of each port simply holds
  wire logic busRise = pinSync[2] & ~clockLast;
  assign syncMode = pinSync[1] & pinSync[0];
  assign selectMismatch = pinSync[1] ^ pinSync[0];
  assign tick = syncMode ? busClockEnable : {2{busRise}};

endmodule

// ==== rtl/bcds_top.sv ====
/*
  Bus clock domain arrangement: a core-side request/response port for each of the five bus
  masters, carried into its bus domain either through synchronisers or, when selected,
  straight through on clock enables.
  Assumes the core clock is sys_clk, the bus clocks and selects come from pins, and the
  bus slaves answer with an AHB-Lite style ready/response.
*/
`timescale 1ns/1ps
module bcds_top
  import bcds_pkg::*;
(
  // Core clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fetch/read/write bus domain
  input wire logic fetchRwBusClock,
  input wire logic fetchRwSyncSelectA,
  input wire logic fetchRwSyncSelectB,
  input wire logic fetchRwBusClockEnable,
  // Peripheral/DMA bus domain
  input wire logic periphDmaBusClock,
  input wire logic periphDmaSyncSelectA,
  input wire logic periphDmaSyncSelectB,
  input wire logic dmaBusClockEnable,
  input wire logic periphBusClockEnable,
  // Core-side requests
  input wire logic [NUM_PORTS-1:0] coreReqValid,
  input wire bcds_req_t [NUM_PORTS-1:0] coreReq,
  output logic [NUM_PORTS-1:0] coreReqReady,
  // Core-side responses
  output logic [NUM_PORTS-1:0] coreRspValid,
  output bcds_rsp_t [NUM_PORTS-1:0] coreRsp,
  // Bus side
  output bcds_bus_out_t [NUM_PORTS-1:0] busOut,
  input wire bcds_bus_in_t [NUM_PORTS-1:0] busIn,
  // Status
  output logic fetchRwSyncMode,
  output logic periphDmaSyncMode,
  output logic fetchRwSelectMismatch,
  output logic periphDmaSelectMismatch,
  output logic [NUM_PORTS-1:0] portBusy
);

  // ****************************************
  // Domain advance generators
  // ****************************************
  logic [1:0] fetchRwTick;
  logic [1:0] periphDmaTick;

  // One shared enable for fetch, read and write
  bcds_tick u_fetch_rw_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .busClock(fetchRwBusClock),
    .syncSelectA(fetchRwSyncSelectA),
    .syncSelectB(fetchRwSyncSelectB),
    .busClockEnable({2{fetchRwBusClockEnable}}),
    .tick(fetchRwTick),
    .syncMode(fetchRwSyncMode),
    .selectMismatch(fetchRwSelectMismatch)
  );

  // Separate enables for the DMA and peripheral ports
  bcds_tick u_periph_dma_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .busClock(periphDmaBusClock),
    .syncSelectA(periphDmaSyncSelectA),
    .syncSelectB(periphDmaSyncSelectB),
    .busClockEnable({periphBusClockEnable, dmaBusClockEnable}),
    .tick(periphDmaTick),
    .syncMode(periphDmaSyncMode),
    .selectMismatch(periphDmaSelectMismatch)
  );

  // ****************************************
  // Ports
  // ****************************************
  genvar p;
  for (p = 0; p < NUM_PORTS; p++) begin : g_port

    localparam logic [1:0] DOMAIN = bcds_port_domain(p);
    localparam int LANE = bcds_port_lane(p);

    bcds_state_t state;
    bcds_state_t next_state;
    bcds_bus_out_t busDrv;
    bcds_bus_out_t next_busDrv;
    bcds_rsp_t rspHold;
    bcds_rsp_t next_rspHold;
    bcds_req_t reqHold;
    bcds_bus_in_t busInSync;
    logic reqFlag;
    logic reqSeen;
    logic rspSeen;
    logic rspPulse;
    bcds_rsp_t rspOut;

    // Port to domain mapping
    wire logic portTick = (DOMAIN == DOM_FETCH_RW) ? fetchRwTick[LANE] : periphDmaTick[LANE];
    wire logic portSync = (DOMAIN == DOM_FETCH_RW) ? fetchRwSyncMode : periphDmaSyncMode;

    // Bus inputs cross in with the same delay as the sampled bus clock
    bcds_sync #(.W($bits(bcds_bus_in_t))) u_bus_in (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn(busIn[p]),
      .syncOut(busInSync)
    );

    // Synchronous mode bypasses the crossing registers on the launch, response and bus input paths
    wire bcds_bus_in_t busInUse = portSync ? busIn[p] : busInSync;
    wire logic launch = portSync ? reqFlag : reqSeen;
    wire logic rspAvail = portSync ? (state == ST_RESP) : rspSeen;
    wire logic rspTake = rspAvail & reqFlag;
    wire logic reqTake = coreReqValid[p] & coreReqReady[p];

    assign coreReqReady[p] = ~reqFlag & ~rspSeen & (state == ST_IDLE);
    assign coreRspValid[p] = rspPulse;
    assign coreRsp[p] = rspOut;
    assign busOut[p] = busDrv;
    assign portBusy[p] = reqFlag | (state != ST_IDLE);

    // ****************************************
    // Core side: request hold and response pulse
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        reqFlag <= 1'b0;
        reqHold <= '0;
      end else if (reqTake) begin
        reqFlag <= 1'b1;
        reqHold <= coreReq[p];
      end else if (rspTake) begin
        reqFlag <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        rspPulse <= 1'b0;
        rspOut <= '0;
      end else begin
        rspPulse <= rspTake;
        if (rspTake) begin
          rspOut <= rspHold;
        end
      end
    end

    // ****************************************
    // Crossing registers; rspSeen also gates coreReqReady in synchronous mode
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        reqSeen <= 1'b0;
        rspSeen <= 1'b0;
      end else begin
        reqSeen <= reqFlag;
        rspSeen <= (state == ST_RESP) & reqFlag;
      end
    end

    // ****************************************
    // Bus side sequencer
    // ****************************************
    always_comb begin
      next_state = state;
      next_busDrv = busDrv;
      next_rspHold = rspHold;
      if (portTick) begin
        case (state)
          ST_IDLE: begin
            if (launch) begin
              next_busDrv.trans = TRANS_NONSEQ;
              next_busDrv.addr = reqHold.addr;
              next_busDrv.write = reqHold.write;
              next_state = ST_ADDR;
            end
          end
          ST_ADDR: begin
            if (busInUse.ready) begin
              next_busDrv.trans = TRANS_IDLE;
              next_busDrv.wdata = reqHold.wdata;
              next_state = ST_DATA;
            end
          end
          ST_DATA: begin
            if (busInUse.ready) begin
              next_rspHold.rdata = busInUse.rdata;
              next_rspHold.err = (busInUse.resp != RESP_OKAY);
              next_state = ST_RESP;
            end
          end
          ST_RESP: begin
            if (!launch) begin
              next_state = ST_IDLE;
            end
          end
          default: begin
            next_busDrv = BUS_OUT_RESET;
            next_state = ST_IDLE;
          end
        endcase
      end
    end

    // State holds without a tick, so stopped clocks lose nothing
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        state <= ST_IDLE;
        busDrv <= BUS_OUT_RESET;
        rspHold <= '0;
      end else begin
        state <= next_state;
        busDrv <= next_busDrv;
        rspHold <= next_rspHold;
      end
    end

  end

endmodule

// ==== testbench/bcds_top_assertions.sv ====
/* Port timing checker for bcds_top.
   Assumes it is bound to bcds_top and sees only its ports. */
`timescale 1ns/1ps
module bcds_top_assertions
  import bcds_pkg::*;
(
  // Clocks, selects and enables
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetchRwBusClock,
  input wire logic fetchRwSyncSelectA,
  input wire logic fetchRwSyncSelectB,
  input wire logic fetchRwBusClockEnable,
  input wire logic periphDmaSyncSelectA,
  input wire logic periphDmaSyncSelectB,
  input wire logic dmaBusClockEnable,
  // Status
  input wire logic fetchRwSyncMode,
  input wire logic periphDmaSyncMode,
  input wire logic fetchRwSelectMismatch,
  input wire logic periphDmaSelectMismatch,
  // Ports
  input wire logic [NUM_PORTS-1:0] coreReqValid,
  input wire logic [NUM_PORTS-1:0] coreReqReady,
  input wire logic [NUM_PORTS-1:0] coreRspValid,
  input wire bcds_bus_out_t [NUM_PORTS-1:0] busOut,
  input wire bcds_bus_in_t [NUM_PORTS-1:0] busIn
);
  // Edges since reset, so the select pipeline is full before modes are judged
  logic [1:0] age;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_fr_mode: assert property (age == 2'h3 |-> {fetchRwSyncMode, fetchRwSelectMismatch} ==
    $past({fetchRwSyncSelectA & fetchRwSyncSelectB, fetchRwSyncSelectA ^ fetchRwSyncSelectB}, 2))
    else $error("fetch domain mode wrong");
  a_pd_mode: assert property (age == 2'h3 |-> {periphDmaSyncMode, periphDmaSelectMismatch} ==
    $past({periphDmaSyncSelectA & periphDmaSyncSelectB, periphDmaSyncSelectA ^ periphDmaSyncSelectB}, 2))
    else $error("dma domain mode wrong");
  a_rsp_pulse: assert property (coreRspValid != '0 |=> (coreRspValid & $past(coreRspValid)) == '0)
    else $error("response pulse too long");
  a_req_refused: assert property ((coreReqValid & coreReqReady) != '0 |=>
    (coreReqReady & $past(coreReqValid & coreReqReady)) == '0)
    else $error("port ready while busy");
  a_sync_latency: assert property (fetchRwSyncMode && coreReqValid[1] && coreReqReady[1] ##1
    (fetchRwBusClockEnable && busIn[1].ready)[*4] |=> coreRspValid[1])
    else $error("sync read latency wrong");
  a_fr_hold: assert property (fetchRwSyncMode && !fetchRwBusClockEnable |=>
    $stable({busOut[0], busOut[1], busOut[2]}))
    else $error("fetch bus moved without enable");
  a_dma_hold: assert property (periphDmaSyncMode && !dmaBusClockEnable |=> $stable(busOut[3]))
    else $error("dma bus moved without enable");
  a_async_stop: assert property (!fetchRwSyncMode && (!$rose(fetchRwBusClock))[*6] |=>
    $stable(busOut[0]))
    else $error("bus moved with stopped clock");
  a_addr_phase: assert property (fetchRwSyncMode && fetchRwBusClockEnable && busIn[1].ready &&
    busOut[1].trans == TRANS_NONSEQ |=> busOut[1].trans == TRANS_IDLE)
    else $error("address phase not single");
endmodule

bind bcds_top bcds_top_assertions i_bcds_top_assertions (.*);

// ==== testbench/bcds_bus_slave.sv ====
/* Bus slave model for the five bus ports.
   Assumes busOut holds between ticks; stall comes from the bench. */
`timescale 1ns/1ps
module bcds_bus_slave
  import bcds_pkg::*;
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic stall,
  // Bus
  input wire bcds_bus_out_t [NUM_PORTS-1:0] busOut,
  output bcds_bus_in_t [NUM_PORTS-1:0] busIn
);
  logic [NUM_PORTS-1:0][ADDR_W-1:0] lastAddr = '0;
  always @(posedge sys_clk) begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (busOut[i].trans == TRANS_NONSEQ) begin
        lastAddr[i] <= busOut[i].addr;
      end
    end
  end
  // Data is a scramble of the address; address bit 0 asks for an error
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      busIn[i].ready = !stall;
      busIn[i].resp = lastAddr[i][0];
      busIn[i].rdata = lastAddr[i] ^ 32'h5A5A0FF0;
    end
  end
endmodule

// ==== testbench/bcds_top_tb.sv ====
/* Self-checking bench for bcds_top with the bus slave model.
   Assumes nothing outside; it makes every clock itself. */
`timescale 1ns/1ps
module bcds_top_tb;
  import bcds_pkg::*;
  typedef struct {int port; logic [31:0] addr; logic write;} bcds_row_t;
  logic sys_clk = 1'b0, rst = 1'b1, busClk = 1'b0, busRun = 1'b1, syncCfg = 1'b0;
  logic frA = 1'b0, frB = 1'b0, pdA = 1'b0, pdB = 1'b0, stall = 1'b0, dmaOn = 1'b1;
  logic frEn = 1'b1, dmaEn = 1'b1, perEn = 1'b1;
  logic [NUM_PORTS-1:0] valid = '0;
  logic [NUM_PORTS-1:0] ready, rspValid;
  bcds_req_t [NUM_PORTS-1:0] req = '0;
  bcds_rsp_t [NUM_PORTS-1:0] rsp;
  bcds_bus_out_t [NUM_PORTS-1:0] busOut;
  bcds_bus_in_t [NUM_PORTS-1:0] busIn;
  logic frMode, pdMode, frMis, pdMis;
  logic [NUM_PORTS-1:0] busy;
  int n_fail = 0, compares = 0, div = 1, cnt = 0, lat = 0;
  bcds_row_t rows [6] = '{'{PORT_FETCH, 32'h00001000, 1'b0}, '{PORT_READ, 32'h20000044, 1'b0},
    '{PORT_WRITE, 32'h20000048, 1'b1}, '{PORT_DMA, 32'h30000010, 1'b0}, '{PORT_PERIPH, 32'h40000008, 1'b1},
    '{PORT_READ, 32'h2000004D, 1'b0}};
  wire hclk = syncCfg ? sys_clk : busClk;
  wire pdClk = (syncCfg && pdA && pdB) ? sys_clk : busClk;
  always #5 sys_clk = ~sys_clk;
  always #40 busClk = busRun ? ~busClk : busClk;
  // Enables pulse once every div core cycles; the DMA enable pulses only while dmaOn is set
  always @(posedge sys_clk) begin
    cnt <= (cnt + 1) % div;
    frEn <= (cnt == 0);
    dmaEn <= (cnt == 0) && dmaOn;
    perEn <= (cnt == 0);
  end
  bcds_top i_bcds_top (.sys_clk(sys_clk), .rst(rst), .fetchRwBusClock(hclk), .fetchRwSyncSelectA(frA),
    .fetchRwSyncSelectB(frB), .fetchRwBusClockEnable(frEn), .periphDmaBusClock(pdClk), .periphDmaSyncSelectA(pdA),
    .periphDmaSyncSelectB(pdB), .dmaBusClockEnable(dmaEn), .periphBusClockEnable(perEn), .coreReqValid(valid),
    .coreReq(req), .coreReqReady(ready), .coreRspValid(rspValid), .coreRsp(rsp), .busOut(busOut), .busIn(busIn),
    .fetchRwSyncMode(frMode), .periphDmaSyncMode(pdMode), .fetchRwSelectMismatch(frMis),
    .periphDmaSelectMismatch(pdMis), .portBusy(busy));
  bcds_bus_slave i_bcds_bus_slave (.sys_clk(sys_clk), .stall(stall), .busOut(busOut), .busIn(busIn));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic restart(input logic a, input logic b, input logic s, input logic [1:0] pd);
    @(posedge sys_clk);
    rst <= 1'b1;
    frA <= a;
    frB <= b;
    pdA <= pd[1];
    pdB <= pd[0];
    syncCfg <= s;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic send(input int p, input logic [31:0] a, input logic w);
    int t;
    t = 0;
    @(posedge sys_clk);
    valid[p] <= 1'b1;
    req[p] <= '{addr: a, write: w, wdata: ~a};
    do begin
      @(negedge sys_clk);
      t++;
    end while (ready[p] !== 1'b1 && t < 400);
    check("request taken", ready[p], 1'b1);
    @(posedge sys_clk);
    valid[p] <= 1'b0;
  endtask
  task automatic collect(input int p, input logic [31:0] a, input logic w, input string what);
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (rspValid[p] !== 1'b1 && lat < 400);
    check({what, " valid"}, rspValid[p], 1'b1);
    check(what, {w ? 32'h0 : rsp[p].rdata, rsp[p].err}, {w ? 32'h0 : a ^ 32'h5A5A0FF0, a[0]});
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    for (int m = 0; m < 2; m++) begin
      restart(m[0], m[0], m[0], {2{m[0]}});
      check("modes", {frMode, pdMode, frMis, pdMis}, {m[0], m[0], 2'b00});
      foreach (rows[i]) begin
        send(rows[i].port, rows[i].addr, rows[i].write);
        collect(rows[i].port, rows[i].addr, rows[i].write, "row response");
        check("row latency", (m == 1) ? lat : (lat > 5), (m == 1) ? 5 : 1);
      end
      $display("table test in mode %0d done", m);
    end
    div = 3;
    send(PORT_READ, 32'h20000100, 1'b0);
    stall <= 1'b1;
    repeat (20) @(posedge sys_clk);
    stall <= 1'b0;
    collect(PORT_READ, 32'h20000100, 1'b0, "slow read");
    check("slow latency", (lat > 5) && (lat < 9), 1);
    $display("ratio test done");
    div = 1;
    dmaOn <= 1'b0;
    send(PORT_DMA, 32'h30000020, 1'b0);
    send(PORT_PERIPH, 32'h40000010, 1'b0);
    collect(PORT_PERIPH, 32'h40000010, 1'b0, "periph alone");
    repeat (20) @(negedge sys_clk);
    check("dma held", busOut[PORT_DMA].trans, TRANS_IDLE);
    check("dma busy", busy[PORT_DMA], 1'b1);
    dmaOn <= 1'b1;
    collect(PORT_DMA, 32'h30000020, 1'b0, "dma resumed");
    $display("enable test done");
    restart(1'b0, 1'b0, 1'b0, 2'b00);
    send(PORT_FETCH, 32'h00002000, 1'b0);
    busRun <= 1'b0;
    repeat (60) @(negedge sys_clk);
    check("stopped port", ready[PORT_FETCH], 1'b0);
    busRun <= 1'b1;
    collect(PORT_FETCH, 32'h00002000, 1'b0, "after clock stop");
    $display("clock stop test done");
    restart(1'b1, 1'b0, 1'b0, 2'b10);
    check("split selects", {frMode, frMis, pdMode, pdMis}, 4'h5);
    $display("select test done");
    restart(1'b1, 1'b1, 1'b1, 2'b00);
    check("mixed modes", {frMode, pdMode, frMis, pdMis}, 4'h8);
    send(PORT_READ, 32'h20000200, 1'b0);
    collect(PORT_READ, 32'h20000200, 1'b0, "sync read beside async");
    check("mixed sync latency", lat, 5);
    send(PORT_PERIPH, 32'h40000020, 1'b0);
    collect(PORT_PERIPH, 32'h40000020, 1'b0, "async periph beside sync");
    check("mixed async latency", lat > 5, 1);
    $display("mixed mode test done");
    finish_test();
  end
  initial begin
    #300us;
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
